// file: tmr2_timer.sv
// Behaviour
// [RULE1] Set high flag on high byte wrap.
// [RULE2] High flag requests interrupt when enabled.
// [RULE3] Flags cleared only by software writes.
// [RULE4] Set low flag on low byte wrap.
// [RULE5] Control bit 5 enables low-byte interrupts.
// [RULE6] Control bit 4 enables capture mode.
// [RULE7] Control bit 3 selects split mode.
// [RULE8] Run bit gates counting; split gates high only.
// [RULE9] Control bit 1 reads zero, writes ignored.
// [RULE10] Bit 0: core/12 or synced external/8.
// [RULE11] Alt select shared; byte selects choose independently.
// [RULE12] Byte select 1 uses undivided core clock.
// [RULE13] 16-bit wrap loads 16-bit reload value.
// [RULE14] Split bytes reload from own reload byte.
// [RULE15] Capture copies count to reload, sets flag.
// [RULE16] Running counters increment per tick, else hold.
`timescale 1ns/1ps
`default_nettype none

module tmr2_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Clock selects from the clock select register
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    // External oscillator divided by 8, asynchronous
    input wire logic ext_clock_div8,
    // Interrupt enable and request
    input wire logic timer_irq_enable,
    output logic irq_request
);

    // Picks the tick for one byte counter.
    function automatic logic pick_tick(input logic byte_sel, input logic alt_sel,
                                       input logic ext_tick, input logic div_tick);
        if (byte_sel) begin
            pick_tick = 1'b1;
        end else if (alt_sel) begin
            pick_tick = ext_tick;
        end else begin
            pick_tick = div_tick;
        end
    endfunction

    // Steps one byte: reload on wrap, otherwise add one.
    function automatic logic [7:0] step_byte(input logic [7:0] value, input logic [7:0] reload);
        if (value == tmr2_pkg::BYTE_MAX) begin
            step_byte = reload;
        end else begin
            step_byte = value + tmr2_pkg::BYTE_ONE;
        end
    endfunction

    // External clock synchroniser and edge detection.
    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;
    logic sync3_reg, sync3_next;
    logic ext_level_reg, ext_level_next;
    logic ext_rise;
    logic ext_fall;

    always_comb begin
        sync1_next = ext_clock_div8;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        ext_level_next = ext_level_reg;
        ext_rise = 1'b0;
        ext_fall = 1'b0;
        // The level only moves once the last two stages agree.
        if (sync2_reg == sync3_reg && sync3_reg != ext_level_reg) begin
            ext_level_next = sync3_reg;
            ext_rise = sync3_reg;
            ext_fall = ~sync3_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            ext_level_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            ext_level_reg <= ext_level_next;
        end
    end

    // Divide-by-12 prescaler of the core clock.
    logic [3:0] div_reg, div_next;
    logic div_tick;

    always_comb begin
        div_tick = (div_reg == tmr2_pkg::DIV_LAST);
        if (div_tick) begin
            div_next = tmr2_pkg::DIV_ZERO;
        end else begin
            div_next = div_reg + tmr2_pkg::DIV_ONE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= tmr2_pkg::DIV_ZERO;
        end else begin
            div_reg <= div_next;
        end
    end

    // Control, count, reload and interrupt state.
    logic high_overflow_flag_reg, high_overflow_flag_next;
    logic low_overflow_flag_reg, low_overflow_flag_next;
    logic low_overflow_irq_enable_reg, low_overflow_irq_enable_next;
    logic capture_mode_enable_reg, capture_mode_enable_next;
    logic split_mode_select_reg, split_mode_select_next;
    logic run_control_reg, run_control_next;
    logic alt_clock_select_reg, alt_clock_select_next;
    logic [7:0] count_low_byte_reg, count_low_byte_next;
    logic [7:0] count_high_byte_reg, count_high_byte_next;
    logic [7:0] reload_low_byte_reg, reload_low_byte_next;
    logic [7:0] reload_high_byte_reg, reload_high_byte_next;
    logic irq_reg, irq_next;
    logic [7:0] rdata_reg, rdata_next;
    logic low_tick;
    logic high_tick;
    logic low_wrap;
    logic high_wrap;
    logic capture_event;
    logic ctl_wr;
    logic [7:0] control_value;

    always_comb begin
        low_tick = pick_tick(low_byte_clock_select, alt_clock_select_reg,
                             ext_rise, div_tick); // see [RULE10] see [RULE11] see [RULE12]
        high_tick = pick_tick(high_byte_clock_select, alt_clock_select_reg,
                              ext_rise, div_tick); // see [RULE11] see [RULE12]
        low_wrap = 1'b0;
        high_wrap = 1'b0;
        count_low_byte_next = count_low_byte_reg;
        count_high_byte_next = count_high_byte_reg;
        reload_low_byte_next = reload_low_byte_reg;
        reload_high_byte_next = reload_high_byte_reg;

        if (split_mode_select_reg) begin // see [RULE7]
            // The low byte always runs in split mode.
            if (low_tick) begin // see [RULE8] see [RULE16]
                low_wrap = (count_low_byte_reg == tmr2_pkg::BYTE_MAX);
                count_low_byte_next = step_byte(count_low_byte_reg, reload_low_byte_reg); // see [RULE14]
            end
            if (run_control_reg && high_tick) begin // see [RULE8] see [RULE16]
                high_wrap = (count_high_byte_reg == tmr2_pkg::BYTE_MAX);
                count_high_byte_next = step_byte(count_high_byte_reg, reload_high_byte_reg); // see [RULE14]
            end
        end else if (run_control_reg && low_tick) begin // see [RULE8] see [RULE16]
            low_wrap = (count_low_byte_reg == tmr2_pkg::BYTE_MAX);
            high_wrap = low_wrap && (count_high_byte_reg == tmr2_pkg::BYTE_MAX);
            if (high_wrap) begin
                count_low_byte_next = reload_low_byte_reg; // see [RULE13]
                count_high_byte_next = reload_high_byte_reg; // see [RULE13]
            end else begin
                count_low_byte_next = count_low_byte_reg + tmr2_pkg::BYTE_ONE;
                if (low_wrap) begin
                    count_high_byte_next = count_high_byte_reg + tmr2_pkg::BYTE_ONE;
                end
            end
        end

        // Capture takes the count as it stands before this edge.
        capture_event = capture_mode_enable_reg && ext_fall; // see [RULE6]
        if (capture_event) begin
            reload_low_byte_next = count_low_byte_reg; // see [RULE15]
            reload_high_byte_next = count_high_byte_reg; // see [RULE15]
        end

        // Software writes to the data bytes take priority over the hardware.
        if (sfr_wr) begin
            unique case (sfr_addr)
                tmr2_pkg::ADDR_RELOAD_LOW: reload_low_byte_next = sfr_wdata;
                tmr2_pkg::ADDR_RELOAD_HIGH: reload_high_byte_next = sfr_wdata;
                tmr2_pkg::ADDR_COUNT_LOW: count_low_byte_next = sfr_wdata;
                tmr2_pkg::ADDR_COUNT_HIGH: count_high_byte_next = sfr_wdata;
                default: begin
                end
            endcase
        end

        ctl_wr = sfr_wr && (sfr_addr == tmr2_pkg::ADDR_CONTROL);
        high_overflow_flag_next = high_overflow_flag_reg;
        low_overflow_flag_next = low_overflow_flag_reg;
        low_overflow_irq_enable_next = low_overflow_irq_enable_reg;
        capture_mode_enable_next = capture_mode_enable_reg;
        split_mode_select_next = split_mode_select_reg;
        run_control_next = run_control_reg;
        alt_clock_select_next = alt_clock_select_reg;
        if (ctl_wr) begin
            high_overflow_flag_next = sfr_wdata[tmr2_pkg::BIT_HIGH_FLAG]; // see [RULE3]
            low_overflow_flag_next = sfr_wdata[tmr2_pkg::BIT_LOW_FLAG]; // see [RULE3]
            low_overflow_irq_enable_next = sfr_wdata[tmr2_pkg::BIT_LOW_IRQ_EN];
            capture_mode_enable_next = sfr_wdata[tmr2_pkg::BIT_CAPTURE_EN]; // see [RULE6]
            split_mode_select_next = sfr_wdata[tmr2_pkg::BIT_SPLIT]; // see [RULE7]
            run_control_next = sfr_wdata[tmr2_pkg::BIT_RUN];
            alt_clock_select_next = sfr_wdata[tmr2_pkg::BIT_ALT_CLOCK]; // see [RULE10]
        end
        // A hardware set in the same cycle as a software clear wins.
        if (high_wrap || capture_event) begin
            high_overflow_flag_next = 1'b1; // see [RULE1] see [RULE15]
        end
        if (low_wrap) begin
            low_overflow_flag_next = 1'b1; // see [RULE4]
        end

        // Interrupt request follows the flags and enables.
        irq_next = timer_irq_enable && (high_overflow_flag_reg
                   || (low_overflow_irq_enable_reg && low_overflow_flag_reg)); // see [RULE2] see [RULE5]

        control_value = tmr2_pkg::CONTROL_RESET;
        control_value[tmr2_pkg::BIT_HIGH_FLAG] = high_overflow_flag_reg;
        control_value[tmr2_pkg::BIT_LOW_FLAG] = low_overflow_flag_reg;
        control_value[tmr2_pkg::BIT_LOW_IRQ_EN] = low_overflow_irq_enable_reg;
        control_value[tmr2_pkg::BIT_CAPTURE_EN] = capture_mode_enable_reg;
        control_value[tmr2_pkg::BIT_SPLIT] = split_mode_select_reg;
        control_value[tmr2_pkg::BIT_RUN] = run_control_reg;
        control_value[tmr2_pkg::BIT_UNUSED] = 1'b0; // see [RULE9]
        control_value[tmr2_pkg::BIT_ALT_CLOCK] = alt_clock_select_reg;

        // Read data is registered and holds between reads.
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            unique case (sfr_addr)
                tmr2_pkg::ADDR_CONTROL: rdata_next = control_value;
                tmr2_pkg::ADDR_RELOAD_LOW: rdata_next = reload_low_byte_reg;
                tmr2_pkg::ADDR_RELOAD_HIGH: rdata_next = reload_high_byte_reg;
                tmr2_pkg::ADDR_COUNT_LOW: rdata_next = count_low_byte_reg;
                tmr2_pkg::ADDR_COUNT_HIGH: rdata_next = count_high_byte_reg;
                default: rdata_next = tmr2_pkg::BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            high_overflow_flag_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_HIGH_FLAG];
            low_overflow_flag_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_LOW_FLAG];
            low_overflow_irq_enable_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_LOW_IRQ_EN];
            capture_mode_enable_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_CAPTURE_EN];
            split_mode_select_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_SPLIT];
            run_control_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_RUN];
            alt_clock_select_reg <= tmr2_pkg::CONTROL_RESET[tmr2_pkg::BIT_ALT_CLOCK];
            count_low_byte_reg <= tmr2_pkg::BYTE_RESET;
            count_high_byte_reg <= tmr2_pkg::BYTE_RESET;
            reload_low_byte_reg <= tmr2_pkg::BYTE_RESET;
            reload_high_byte_reg <= tmr2_pkg::BYTE_RESET;
            irq_reg <= 1'b0;
            rdata_reg <= tmr2_pkg::BYTE_RESET;
        end else begin
            high_overflow_flag_reg <= high_overflow_flag_next;
            low_overflow_flag_reg <= low_overflow_flag_next;
            low_overflow_irq_enable_reg <= low_overflow_irq_enable_next;
            capture_mode_enable_reg <= capture_mode_enable_next;
            split_mode_select_reg <= split_mode_select_next;
            run_control_reg <= run_control_next;
            alt_clock_select_reg <= alt_clock_select_next;
            count_low_byte_reg <= count_low_byte_next;
            count_high_byte_reg <= count_high_byte_next;
            reload_low_byte_reg <= reload_low_byte_next;
            reload_high_byte_reg <= reload_high_byte_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign irq_request = irq_reg;

endmodule // tmr2_timer

`default_nettype wire

// file: tmr2_pkg.sv
package tmr2_pkg;

    // Special-function register addresses.
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

    // Control register field positions.
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_UNUSED = 1;
    localparam int BIT_ALT_CLOCK = 0;

    // Reset values.
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Byte limits.
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // Core clock divider for the slow tick.
    localparam int CORE_DIVIDE = 12;
    localparam logic [3:0] DIV_LAST = 4'(CORE_DIVIDE - 1);
    localparam logic [3:0] DIV_ZERO = 4'h0;
    localparam logic [3:0] DIV_ONE = 4'h1;

    // Core clock rate, used to relate ticks to time.
    localparam int CORE_CLOCK_HZ = 25000000;
    localparam int CORE_PERIOD_NS = 1000000000 / CORE_CLOCK_HZ;

endpackage : tmr2_pkg

// file: tmr2_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Selects and interrupt
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic ext_clock_div8,
    input wire logic timer_irq_enable,
    input wire logic irq_request
);
    logic rd_ctl, wr_ctl, rd_lo, rd_hi, rdc_reg, rdc_next, dirty_reg, dirty_next;
    logic [1:0] seen_reg, seen_next;
    logic [5:0] sw_reg, sw_next;
    assign rd_ctl = sfr_rd && sfr_addr == tmr2_pkg::ADDR_CONTROL;
    assign wr_ctl = sfr_wr && sfr_addr == tmr2_pkg::ADDR_CONTROL;
    assign rd_lo = sfr_rd && sfr_addr == tmr2_pkg::ADDR_COUNT_LOW;
    assign rd_hi = sfr_rd && sfr_addr == tmr2_pkg::ADDR_COUNT_HIGH;
    // Tracks software-written control bits and the flags seen at the last control read.
    always_comb begin
        rdc_next = rd_ctl;
        sw_next = wr_ctl ? sfr_wdata[5:0] : sw_reg;
        // A control write may clear flags, so what was seen before it no longer binds.
        seen_next = wr_ctl ? 2'h0 : (rdc_reg ? sfr_rdata[7:6] : seen_reg);
        dirty_next = wr_ctl || (dirty_reg && !rd_ctl);
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdc_reg <= 1'b0;
            sw_reg <= 6'h00;
            seen_reg <= 2'h0;
            dirty_reg <= 1'b0;
        end else begin
            rdc_reg <= rdc_next;
            sw_reg <= sw_next;
            seen_reg <= seen_next;
            dirty_reg <= dirty_next;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_unused_reads_zero: assert property (rd_ctl |=> !sfr_rdata[1])
        else $error("unused control bit read back as one");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    a_control_readback: assert property (rd_ctl |=> {sfr_rdata[5:2], sfr_rdata[0]} ==
        $past({sw_reg[5:2], sw_reg[0]})) else $error("control bits differ from last write");
    a_irq_from_flags: assert property (rd_ctl |=> irq_request == ($past(timer_irq_enable) &&
        (sfr_rdata[7] || (sfr_rdata[5] && sfr_rdata[6])))) else $error("interrupt does not follow flags");
    a_irq_needs_enable: assert property (irq_request |-> $past(timer_irq_enable))
        else $error("interrupt raised while disabled");
    a_flags_stay_set: assert property (rd_ctl && !dirty_reg |=> (sfr_rdata[7:6] & seen_reg) == seen_reg)
        else $error("overflow flag cleared without a write");
    a_low_steps_fast: assert property (rd_lo && low_byte_clock_select && sw_reg[3] && !sfr_wr
        ##1 rd_lo && !sfr_wr ##1 $past(sfr_rdata) != 8'hff |-> sfr_rdata == $past(sfr_rdata) + 8'h01)
        else $error("low byte did not step by one");
    a_high_held: assert property (rd_hi && sw_reg[3] && !sw_reg[2] && !sfr_wr ##1 rd_hi && !sfr_wr
        |=> $stable(sfr_rdata)) else $error("stopped high byte moved");
    c_irq: cover property (irq_request);
    c_high_flag: cover property (rdc_reg && sfr_rdata[7]);
    c_low_flag: cover property (rdc_reg && sfr_rdata[6] && !sfr_rdata[7]);
endmodule // tmr2_monitor
bind tmr2_timer tmr2_monitor u_mon (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .high_byte_clock_select, .low_byte_clock_select, .ext_clock_div8, .timer_irq_enable, .irq_request);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] CTL = tmr2_pkg::ADDR_CONTROL;
    logic mclk, rst, wr, rd, hsel, lsel, ext, irq_en, irq;
    logic [7:0] addr, wdata, rdata, v, w;
    int n_errors = 0;
    int n_checks = 0;
    tmr2_timer dut (.mclk(mclk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
        .sfr_rdata(rdata), .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
        .ext_clock_div8(ext), .timer_irq_enable(irq_en), .irq_request(irq));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask
    // Two reads in back-to-back cycles.
    task automatic rd_pair(input logic [7:0] a, output logic [7:0] first, output logic [7:0] second);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        first = rdata;
        @(negedge mclk);
        rd = 1'b0;
        second = rdata;
    endtask
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 300 && irq !== lvl; i++) @(negedge mclk);
        check("irq_request", {7'h00, lvl}, {7'h00, irq});
        if (irq !== lvl) summarize();
    endtask
    task automatic s_control();
        rd_pair(CTL, v, w);
        check("control reset", 8'h00, v);
        rd_pair(8'hc9, v, w);
        check("unmapped", 8'h00, v);
        wr_reg(CTL, 8'hff);
        rd_pair(CTL, v, w);
        check("control ones", 8'hfd, v);
        wait_irq(1'b1);
        irq_en = 1'b0;
        wait_irq(1'b0);
        irq_en = 1'b1;
        wr_reg(CTL, 8'h00);
        rd_pair(CTL, v, w);
        check("control cleared", 8'h00, v);
    endtask
    task automatic s_wrap16();
        lsel = 1'b1;
        wr_reg(tmr2_pkg::ADDR_RELOAD_HIGH, 8'h12);
        wr_reg(tmr2_pkg::ADDR_RELOAD_LOW, 8'h34);
        wr_reg(tmr2_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr_reg(tmr2_pkg::ADDR_COUNT_LOW, 8'hf0);
        wr_reg(CTL, 8'h04);
        wait_irq(1'b1);
        // Flags must come from the wrap itself, so read before any control write.
        rd_pair(CTL, v, w);
        check("wrap flags", 8'hc4, v);
        wr_reg(CTL, 8'hc0);
        rd_pair(tmr2_pkg::ADDR_COUNT_HIGH, v, w);
        check("reloaded high", 8'h12, v);
        wr_reg(CTL, 8'h00);
        wait_irq(1'b0);
    endtask
    task automatic s_split();
        hsel = 1'b1;
        wr_reg(tmr2_pkg::ADDR_COUNT_HIGH, 8'h55);
        wr_reg(tmr2_pkg::ADDR_RELOAD_LOW, 8'h80);
        wr_reg(tmr2_pkg::ADDR_COUNT_LOW, 8'hfe);
        wr_reg(CTL, 8'h28);
        wait_irq(1'b1);
        rd_pair(tmr2_pkg::ADDR_COUNT_HIGH, v, w);
        check("stopped high", 8'h55, w);
        rd_pair(tmr2_pkg::ADDR_COUNT_LOW, v, w);
        check("low reload", 8'h08, {4'h0, v[7:4]});
        check("low step", v + 8'h01, w);
        rd_pair(CTL, v, w);
        check("split flags", 8'h68, v);
        wr_reg(CTL, 8'h0c);
        // The request from the low flag lingers one cycle after the clearing write.
        wait_irq(1'b0);
        wait_irq(1'b1);
        rd_pair(tmr2_pkg::ADDR_COUNT_HIGH, v, w);
        check("high reload", 8'h01, {4'h0, v[7:4]});
        hsel = 1'b0;
        lsel = 1'b0;
        wr_reg(CTL, 8'h00);
    endtask
    task automatic s_capture();
        wr_reg(tmr2_pkg::ADDR_COUNT_HIGH, 8'hab);
        wr_reg(tmr2_pkg::ADDR_COUNT_LOW, 8'hcd);
        wr_reg(CTL, 8'h10);
        ext = 1'b1;
        repeat (6) @(negedge mclk);
        ext = 1'b0;
        repeat (6) @(negedge mclk);
        rd_pair(tmr2_pkg::ADDR_RELOAD_HIGH, v, w);
        check("capture high", 8'hab, v);
        rd_pair(tmr2_pkg::ADDR_RELOAD_LOW, v, w);
        check("capture low", 8'hcd, v);
        rd_pair(CTL, v, w);
        check("capture flag", 8'h90, v);
        wr_reg(CTL, 8'h00);
    endtask
    task automatic s_clocks();
        wr_reg(tmr2_pkg::ADDR_COUNT_LOW, 8'h00);
        wr_reg(CTL, 8'h05);
        repeat (4) begin
            ext = 1'b1;
            repeat (5) @(negedge mclk);
            ext = 1'b0;
            repeat (5) @(negedge mclk);
        end
        rd_pair(tmr2_pkg::ADDR_COUNT_LOW, v, w);
        check("external ticks", 8'h04, v);
        wr_reg(CTL, 8'h04);
        rd_pair(tmr2_pkg::ADDR_COUNT_LOW, v, w);
        // Exactly 120 core edges lie between the two samples, so ten ticks whatever the prescaler phase.
        repeat (116) @(negedge mclk);
        rd_pair(tmr2_pkg::ADDR_COUNT_LOW, w, w);
        check("divided ticks", v + 8'h0a, w);
    endtask
    initial begin
        rst = 1'b1;
        {wr, rd, hsel, lsel, ext} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        irq_en = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        s_control();
        s_wrap16();
        s_split();
        s_capture();
        s_clocks();
        summarize();
    end
endmodule // testbench
`default_nettype wire
